// File: inc/ssp_pkg.sv
// shared constants, register layouts and pin carriers of the serial port block
package ssp_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // register byte offsets on the avalon slave
   localparam logic [4:0] SSP_OFS_MODE    = 5'h00;
   localparam logic [4:0] SSP_OFS_FMT     = 5'h04;
   localparam logic [4:0] SSP_OFS_DATA    = 5'h08;
   localparam logic [4:0] SSP_OFS_IRQ_ST  = 5'h0c;
   localparam logic [4:0] SSP_OFS_IRQ_CLR = 5'h10;
   localparam logic [4:0] SSP_OFS_IRQ_EN  = 5'h14;

   ////////////////////////////////////////////////////////////////////////////
   // operating modes of the three-bit mode field
   typedef enum logic [2:0] {
      SSP_M_DIV4  = 3'b000,
      SSP_M_DIV16 = 3'b001,
      SSP_M_DIV64 = 3'b010,
      SSP_M_SUB   = 3'b011,
      SSP_M_TMR   = 3'b100,
      SSP_M_SLAVE = 3'b101,
      SSP_M_TWI   = 3'b110,
      SSP_M_NONE  = 3'b111
   } ssp_mode_e;

   // serial_mode_control layout, msb first
   typedef struct packed {
      ssp_mode_e  operating_mode_field;
      logic       unused4;
      logic [1:0] debounce_select;
      logic       module_enable;
      logic       slave_incomplete_flag;
   } ssp_mode_ctrl_s;

   // serial_format_flags layout, msb first
   typedef struct packed {
      logic [1:0] spare;
      logic       clock_idle_polarity;
      logic       clock_edge_select;
      logic       bit_order_select;
      logic       select_pin_enable;
      logic       write_collision_flag;
      logic       transfer_complete_flag;
   } ssp_fmt_s;

   localparam logic [7:0] SSP_MODE_CTRL_RST = 8'he0;
   localparam logic [7:0] SSP_FMT_RST       = 8'h00;
   localparam logic [7:0] SSP_DATA_RST      = 8'h00;

   ////////////////////////////////////////////////////////////////////////////
   // interrupt status bit positions
   localparam int         SSP_IRQ_DONE = 0;
   localparam int         SSP_IRQ_COLL = 1;
   localparam int         SSP_IRQ_INC  = 2;
   localparam logic [2:0] SSP_IRQ_RST  = 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // timing: full serial clock period in system cycles per divider mode, and half-period counter limits
   localparam int         SSP_DIV4     = 4;
   localparam int         SSP_DIV16    = 16;
   localparam int         SSP_DIV64    = 64;
   localparam logic [4:0] SSP_HALF_4   = 5'(SSP_DIV4 / 2 - 1);
   localparam logic [4:0] SSP_HALF_16  = 5'(SSP_DIV16 / 2 - 1);
   localparam logic [4:0] SSP_HALF_64  = 5'(SSP_DIV64 / 2 - 1);
   localparam logic [3:0] SSP_LAST_EDGE = 4'hf;
   localparam logic [3:0] SSP_BITS     = 4'h8;

   ////////////////////////////////////////////////////////////////////////////
   // pin carriers
   typedef struct packed {
      logic sck;
      logic serial_data_in;
      logic scs_n;
   } ssp_pin_in_s;

   typedef struct packed {
      logic sck_o;
      logic sck_oe;
      logic sdo_o;
      logic sdo_oe;
      logic scs_n_o;
      logic scs_n_oe;
   } ssp_pin_out_s;

endpackage : ssp_pkg

// File: src/ssp_rate_gen.sv
// serial clock half-period tick generator for master mode
`timescale 1ns/1ps
module ssp_rate_gen (
   input  wire logic              sys_clk,
   input  wire logic              nrst,
   input  wire ssp_pkg::ssp_mode_e mode,
   input  wire logic              run,
   input  wire logic              sub_lvl,
   input  wire logic              tmr_tick,
   output logic                   half_tick
);
   import ssp_pkg::*;

   logic [4:0] cnt_ff;
   logic [4:0] nxt_cnt;
   logic       sub_prev_ff;
   logic       nxt_sub_prev;
   logic [4:0] lim;

   ////////////////////////////////////////////////////////////////////////////
   // counter restarts while idle so the first half period is full length
   always_comb begin
      lim          = SSP_HALF_4;
      half_tick    = 1'b0;
      nxt_sub_prev = sub_lvl;
      case (mode)
         SSP_M_DIV4:  lim = SSP_HALF_4;
         SSP_M_DIV16: lim = SSP_HALF_16;
         SSP_M_DIV64: lim = SSP_HALF_64;
         default:     lim = SSP_HALF_4;
      endcase
      nxt_cnt = (run && cnt_ff != lim) ? cnt_ff + 5'h01 : 5'h00;
      case (mode)
         SSP_M_DIV4, SSP_M_DIV16, SSP_M_DIV64: half_tick = run && cnt_ff == lim;
         // sub clock: each sub-clock edge is a half period
         SSP_M_SUB: half_tick = run && (sub_lvl != sub_prev_ff);
         // timer: each match toggles, giving half the match rate
         SSP_M_TMR: half_tick = run && tmr_tick;
         default:   half_tick = 1'b0;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cnt_ff      <= 5'h00;
         sub_prev_ff <= 1'b0;
      end else begin
         cnt_ff      <= nxt_cnt;
         sub_prev_ff <= nxt_sub_prev;
      end
   end

endmodule : ssp_rate_gen

// File: src/ssp_port.sv
// four-line serial port, master or slave, with avalon register slave
// How it works
// [R01] four lines: data in, data out, serial clock, active-low select
// [R02] full duplex; the port works as master or as slave
// [R03] only a master starts transfers and drives the clock
// [R04] select enable 1 uses the select pin; 0 leaves it floating
// [R05] further slaves are picked by the far master through general i/o
// [R06] bit order selects lsb first or msb first
// [R07] active serial clock edge is rising or falling
// [R08] mode field bits 7..5 picks serial or two-wire personality
// [R09] lines work only with pin function, enable and mode set
// [R10] pull-ups apply on enabled input pins only
// [R11] mode register: mode, debounce, enable, incomplete flag; bit 4 zero
// [R12] format register: spare, polarity, edge, order, select, collision, done
// [R13] modes: master at /4, /16, /64, sub clock, timer half; slave
// [R14] polarity sets idle level; edge bit picks capture edge
// [R15] data write during a transfer is dropped and flags a collision
// [R16] early deselect in slave sets incomplete and done flags
// [R17] eight bits per transfer; done flag after the last edge
// [R18] master starts on an idle data write and holds select low
`timescale 1ns/1ps
module ssp_port (
   input  wire logic                 sys_clk,
   input  wire logic                 nrst,
   input  wire logic [4:0]           avs_address,
   input  wire logic                 avs_read,
   input  wire logic                 avs_write,
   input  wire logic [3:0]           avs_byteenable,
   input  wire logic [31:0]          avs_writedata,
   output logic [31:0]               avs_readdata,
   output logic                      avs_waitrequest,
   input  wire ssp_pkg::ssp_pin_in_s pin_i,
   output ssp_pkg::ssp_pin_out_s     pin_o,
   input  wire logic                 pin_func_sel,
   input  wire logic [2:0]           pull_up_sel,
   output logic [2:0]                pull_up_on,
   input  wire logic                 sub_clk_in,
   input  wire logic                 timer_match,
   output logic                      irq
);
   import ssp_pkg::*;

   ////////////////////////////////////////////////////////////////////////////
   // helpers
   function automatic logic ssp_hit(input logic [4:0] a, input logic [4:0] ofs);
      ssp_hit = (a[4:2] == ofs[4:2]);
   endfunction : ssp_hit

   function automatic logic ssp_first(input logic [7:0] v, input logic msb);
      ssp_first = msb ? v[7] : v[0];
   endfunction : ssp_first

   function automatic logic [7:0] ssp_shift(input logic [7:0] v, input logic b, input logic msb);
      ssp_shift = msb ? {v[6:0], b} : {b, v[7:1]};
   endfunction : ssp_shift

   ssp_mode_ctrl_s ctrl_ff, nxt_ctrl;
   ssp_fmt_s       fmt_ff, nxt_fmt;
   logic [2:0]     irq_st_ff, nxt_irq_st, irq_en_ff, nxt_irq_en;
   logic [7:0]     data_ff, nxt_data;
   logic [3:0]     half_ff, nxt_half;
   logic           busy_ff, nxt_busy, sck_ff, nxt_sck, out_ff, nxt_out;
   logic           rd_wait_ff, nxt_rd_wait;
   logic [31:0]    rdata_ff, nxt_rdata;
   logic [2:0]     sck_s_ff, scs_s_ff;
   logic [1:0]     sdi_s_ff, sub_s_ff;
   logic           active, master, slave, msb, lead_cap, idle_lvl, sel_ok;
   logic           half_tick, edge_ev, cap_ev, inc_cond;
   logic           done_evt, coll_evt, inc_evt;
   logic           wr_acc, wr_mode, wr_fmt, wr_data, wr_clr, wr_en;

   ////////////////////////////////////////////////////////////////////////////
   // two-flop synchronisers; the third stage only feeds edge detection
   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         // clock idles high at reset polarity, so no false edge follows reset
         sck_s_ff <= 3'h7;
         scs_s_ff <= 3'h7;
         sdi_s_ff <= 2'h0;
         sub_s_ff <= 2'h0;
      end else begin
         sck_s_ff <= {sck_s_ff[1:0], pin_i.sck};
         scs_s_ff <= {scs_s_ff[1:0], pin_i.scs_n};
         sdi_s_ff <= {sdi_s_ff[0], pin_i.serial_data_in};
         sub_s_ff <= {sub_s_ff[0], sub_clk_in};
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // personality and mode decode
   // [R08] [R09] pins serve only in a serial mode with enable and pin select
   assign active   = pin_func_sel && ctrl_ff.module_enable &&
                     (ctrl_ff.operating_mode_field <= SSP_M_SLAVE);
   // [R13] modes below slave are master with their own clock source
   assign master   = active && (ctrl_ff.operating_mode_field != SSP_M_SLAVE);
   assign slave    = active && (ctrl_ff.operating_mode_field == SSP_M_SLAVE);
   assign msb      = fmt_ff.bit_order_select;
   // [R14] polarity 0 idles high; edge bit 1 captures on the leading edge
   assign idle_lvl = ~fmt_ff.clock_idle_polarity;
   assign lead_cap = fmt_ff.clock_edge_select;
   // [R04] with select disabled the slave is always addressed
   assign sel_ok   = ~fmt_ff.select_pin_enable | ~scs_s_ff[1];

   ssp_rate_gen u_rate (
      .sys_clk   (sys_clk),
      .nrst      (nrst),
      .mode      (ctrl_ff.operating_mode_field),
      .run       (master && busy_ff),
      .sub_lvl   (sub_s_ff[1]),
      .tmr_tick  (timer_match),
      .half_tick (half_tick)
   );

   // [R03] slave edges come only from the far master's clock
   assign edge_ev  = master ? (busy_ff && half_tick)
                            : (slave && sel_ok && (sck_s_ff[1] ^ sck_s_ff[2]));
   // [R07] even edge counts are leading edges
   assign cap_ev   = edge_ev && ((~half_ff[0]) == lead_cap);
   // [R16] select released mid transfer
   assign inc_cond = slave && fmt_ff.select_pin_enable && busy_ff && scs_s_ff[1] && !scs_s_ff[2];

   ////////////////////////////////////////////////////////////////////////////
   // bus decode; writes never wait, reads take one wait state
   assign wr_acc  = avs_write && avs_byteenable[0];
   assign wr_mode = wr_acc && ssp_hit(avs_address, SSP_OFS_MODE);
   assign wr_fmt  = wr_acc && ssp_hit(avs_address, SSP_OFS_FMT);
   assign wr_data = wr_acc && ssp_hit(avs_address, SSP_OFS_DATA);
   assign wr_clr  = wr_acc && ssp_hit(avs_address, SSP_OFS_IRQ_CLR);
   assign wr_en   = wr_acc && ssp_hit(avs_address, SSP_OFS_IRQ_EN);
   assign avs_waitrequest = avs_read && !rd_wait_ff;
   assign avs_readdata    = rdata_ff;

   always_comb begin
      nxt_rd_wait = avs_read && !rd_wait_ff;
      nxt_rdata   = rdata_ff;
      if (avs_read && !rd_wait_ff) begin
         nxt_rdata = 32'h0;
         case (avs_address[4:2])
            SSP_OFS_MODE[4:2]:   nxt_rdata[7:0] = {ctrl_ff[7:5], 1'b0, ctrl_ff[3:0]};
            SSP_OFS_FMT[4:2]:    nxt_rdata[7:0] = fmt_ff;
            SSP_OFS_DATA[4:2]:   nxt_rdata[7:0] = data_ff;
            SSP_OFS_IRQ_ST[4:2]: nxt_rdata[2:0] = irq_st_ff;
            SSP_OFS_IRQ_EN[4:2]: nxt_rdata[2:0] = irq_en_ff;
            default:             nxt_rdata = 32'h0;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         rd_wait_ff <= 1'b0;
         rdata_ff   <= 32'h0;
      end else begin
         rd_wait_ff <= nxt_rd_wait;
         rdata_ff   <= nxt_rdata;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // transfer engine shared by master and slave
   always_comb begin
      nxt_busy = busy_ff;
      nxt_half = half_ff;
      nxt_out  = out_ff;
      nxt_data = data_ff;
      done_evt = 1'b0;
      coll_evt = 1'b0;
      inc_evt  = 1'b0;
      if (wr_data) begin
         // [R15] a busy shifter keeps its data
         if (busy_ff) begin
            coll_evt = 1'b1;
         end else begin
            // [R18] master starts on an idle write; slave just preloads
            nxt_data = avs_writedata[7:0];
            nxt_out  = ssp_first(avs_writedata[7:0], msb);
            nxt_busy = master;
            nxt_half = 4'h0;
         end
      end
      if (!active) begin
         nxt_busy = 1'b0;
         nxt_half = 4'h0;
      end else if (inc_cond) begin
         // [R16] abandon the byte and flag it
         nxt_busy = 1'b0;
         nxt_half = 4'h0;
         inc_evt  = 1'b1;
      end else if (edge_ev) begin
         nxt_busy = 1'b1;
         nxt_half = half_ff + 4'h1;
         // [R02] [R06] capture in and shift out in the chosen order
         if (cap_ev) begin
            nxt_data = ssp_shift(data_ff, sdi_s_ff[1], msb);
         end else begin
            nxt_out = ssp_first(data_ff, msb);
         end
         // [R17] sixteen edges carry eight bits
         if (half_ff == SSP_LAST_EDGE) begin
            nxt_busy = 1'b0;
            done_evt = 1'b1;
         end
      end
      // [R14] clock rests at its idle level outside a master transfer
      nxt_sck = (master && nxt_busy) ? (edge_ev ? ~sck_ff : sck_ff) : idle_lvl;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         busy_ff <= 1'b0;
         half_ff <= 4'h0;
         sck_ff  <= 1'b1;
         out_ff  <= 1'b0;
         data_ff <= SSP_DATA_RST;
      end else begin
         busy_ff <= nxt_busy;
         half_ff <= nxt_half;
         sck_ff  <= nxt_sck;
         out_ff  <= nxt_out;
         data_ff <= nxt_data;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // control registers and interrupt; hardware set beats software clear
   always_comb begin
      nxt_ctrl   = ctrl_ff;
      nxt_fmt    = fmt_ff;
      nxt_irq_en = wr_en ? avs_writedata[2:0] : irq_en_ff;
      // [R11] bit 4 is not kept
      if (wr_mode) begin
         nxt_ctrl = ssp_mode_ctrl_s'({avs_writedata[7:5], 1'b0, avs_writedata[3:0]});
      end
      // [R12] the two flags are writable by software
      if (wr_fmt) begin
         nxt_fmt = ssp_fmt_s'(avs_writedata[7:0]);
      end
      // [R16] incomplete raises the done flag too
      nxt_ctrl.slave_incomplete_flag = nxt_ctrl.slave_incomplete_flag | inc_evt;
      nxt_fmt.write_collision_flag   = nxt_fmt.write_collision_flag | coll_evt;
      // [R17] done flag
      nxt_fmt.transfer_complete_flag = nxt_fmt.transfer_complete_flag | done_evt | inc_evt;
      nxt_irq_st = irq_st_ff & ~(wr_clr ? avs_writedata[2:0] : 3'h0);
      nxt_irq_st[SSP_IRQ_DONE] = nxt_irq_st[SSP_IRQ_DONE] | done_evt | inc_evt;
      nxt_irq_st[SSP_IRQ_COLL] = nxt_irq_st[SSP_IRQ_COLL] | coll_evt;
      nxt_irq_st[SSP_IRQ_INC]  = nxt_irq_st[SSP_IRQ_INC] | inc_evt;
   end

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         ctrl_ff   <= ssp_mode_ctrl_s'(SSP_MODE_CTRL_RST);
         fmt_ff    <= ssp_fmt_s'(SSP_FMT_RST);
         irq_st_ff <= SSP_IRQ_RST;
         irq_en_ff <= SSP_IRQ_RST;
      end else begin
         ctrl_ff   <= nxt_ctrl;
         fmt_ff    <= nxt_fmt;
         irq_st_ff <= nxt_irq_st;
         irq_en_ff <= nxt_irq_en;
      end
   end

   assign irq = |(irq_st_ff & irq_en_ff);

   ////////////////////////////////////////////////////////////////////////////
   // pins; the master's data-in path lags two cycles, so /4 has no margin
   // [R01] [R03] master owns clock; select driven only when enabled
   assign pin_o.sck_o    = sck_ff;
   assign pin_o.sck_oe   = master;
   assign pin_o.sdo_o    = out_ff;
   assign pin_o.sdo_oe   = master || (slave && sel_ok);
   // [R04] [R18] select low for the whole master transfer
   assign pin_o.scs_n_o  = ~busy_ff;
   assign pin_o.scs_n_oe = master && fmt_ff.select_pin_enable;
   // [R10] pull-ups: bit 2 data in, bit 1 clock, bit 0 select
   assign pull_up_on = active ? (pull_up_sel & {1'b1, slave, slave && fmt_ff.select_pin_enable}) : 3'h0;

   ////////////////////////////////////////////////////////////////////////////
   // checks
   logic [3:0] cap_cnt_ff;

   always_ff @(posedge sys_clk) begin
      if (!nrst) begin
         cap_cnt_ff <= 4'h0;
      end else begin
         cap_cnt_ff <= (busy_ff ? cap_cnt_ff : 4'h0) + {3'h0, cap_ev};
      end
   end

   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!nrst);

   a_pins_off:    assert property (!active |-> !pin_o.sck_oe && !pin_o.sdo_oe && !pin_o.scs_n_oe) // [R09]
      else $error("pins driven while port inactive");
   a_twi_off:     assert property (ctrl_ff.operating_mode_field == SSP_M_TWI |-> !active) // [R08]
      else $error("two-wire mode left serial port active");
   a_scs_float:   assert property (!fmt_ff.select_pin_enable |-> !pin_o.scs_n_oe) // [R04]
      else $error("select pin driven while disabled");
   a_slave_noclk: assert property (slave |-> !pin_o.sck_oe && !pin_o.scs_n_oe) // [R03]
      else $error("slave drives serial clock");
   a_master_go:   assert property (wr_data && master && !busy_ff |=> busy_ff ##1 busy_ff) // [R18]
      else $error("idle master write did not start a transfer");
   a_select_held: assert property (master && busy_ff && fmt_ff.select_pin_enable
                                   |-> pin_o.scs_n_oe && !pin_o.scs_n_o) // [R18]
      else $error("select not held low during master transfer");
   a_sck_idle:    assert property (master && !busy_ff && $stable(fmt_ff.clock_idle_polarity)
                                   && $past(!busy_ff) |-> pin_o.sck_o == ~fmt_ff.clock_idle_polarity) // [R14]
      else $error("serial clock away from idle level");
   a_write_collision_flag_set:    assert property (wr_data && busy_ff |=> fmt_ff.write_collision_flag
                                   && irq_st_ff[SSP_IRQ_COLL]) // [R15]
      else $error("collision flag not set");
   a_inc_trf:     assert property (inc_evt |=> ctrl_ff.slave_incomplete_flag && fmt_ff.transfer_complete_flag
                                   && irq_st_ff[SSP_IRQ_INC] && !busy_ff) // [R16]
      else $error("incomplete did not raise both flags");
   a_eight_bits:  assert property (done_evt |-> cap_cnt_ff + {3'h0, cap_ev} == SSP_BITS) // [R17]
      else $error("transfer ended without eight captures");
   a_pullup:      assert property (|pull_up_on |-> active) // [R10]
      else $error("pull-up applied while inactive");

   c_master_done: cover property (master && done_evt);
   c_slave_done:  cover property (slave && done_evt);
   c_incomplete:  cover property (inc_evt);
   c_collision:   cover property (coll_evt ##1 irq);

endmodule : ssp_port

// File: testbench/ssp_far_model.sv
// behavioural far-side serial peripheral: sends one byte, collects one
`timescale 1ns/1ps
module ssp_far_model (
   input  wire logic       sck,
   input  wire logic       scs_n,
   input  wire logic       mosi,
   input  wire logic       pol,
   input  wire logic       edg,
   input  wire logic       msb,
   input  wire logic [7:0] tx,
   output logic            miso,
   output logic [7:0]      rx
);
   int idx;
   initial begin
      miso = 1'b1;
      rx = 8'h00;
      idx = 0;
   end
   ////////////////////////////////////////////////////////////////////////////
   // frame opens on select; leading capture (edge bit 1) needs the first bit up front
   always @(negedge scs_n) begin
      idx = 0;
      if (edg) begin
         miso = msb ? tx[7] : tx[0];
         idx = 1;
      end
   end
   // capture on the chosen edge, launch on the other
   always @(sck) begin
      // capture ignores select: a master may lift it in the step of its last edge;
      // stray idle captures are pushed out by the eight of the next frame
      if (sck == (pol == edg)) rx = msb ? {rx[6:0], mosi} : {mosi, rx[7:1]};
      else if (!scs_n && idx < 8) begin
         miso = msb ? tx[7 - idx] : tx[idx];
         idx++;
      end
   end
   // released line must not keep a stale bit, so it flips
   always @(posedge scs_n) miso = ~miso;
endmodule : ssp_far_model

// File: testbench/tb.sv
// self-checking bench of the serial port over its avalon slave
`timescale 1ns/1ps
module tb;
   import ssp_pkg::*;
   logic         sys_clk, nrst, rd_en, wr_en, pf, tb_sck, tb_scs_n, pol, edg, msb, miso;
   logic         wait_req, irq, sub_clk, tmr;
   logic [4:0]   addr;
   logic [31:0]  wdata, rdata;
   logic [2:0]   pu_sel, pu_on;
   logic [7:0]   tx, rx;
   ssp_pin_in_s  pin_i;
   ssp_pin_out_s pin_o;
   int           failures, comparisons, cycles;
   // wire level: the driving party wins, select idles high
   // one select line only; any further slave would hang on general i/o
   assign pin_i = {pin_o.sck_oe ? pin_o.sck_o : tb_sck, miso, pin_o.scs_n_oe ? pin_o.scs_n_o : tb_scs_n};
   ssp_port ssp_port_inst (.sys_clk(sys_clk), .nrst(nrst), .avs_address(addr), .avs_read(rd_en),
      .avs_write(wr_en), .avs_byteenable(4'h1), .avs_writedata(wdata), .avs_readdata(rdata),
      .avs_waitrequest(wait_req), .pin_i(pin_i), .pin_o(pin_o), .pin_func_sel(pf), .pull_up_sel(pu_sel),
      .pull_up_on(pu_on), .sub_clk_in(sub_clk), .timer_match(tmr), .irq(irq));
   ssp_far_model ssp_far_model_inst (.sck(pin_i.sck), .scs_n(pin_i.scs_n), .mosi(pin_o.sdo_o), .pol(pol),
      .edg(edg), .msb(msb), .tx(tx), .miso(miso), .rx(rx));
   ////////////////////////////////////////////////////////////////////////////
   // clock and hang guard
   always #4 sys_clk = ~sys_clk;
   // sub clock toggles every 4 cycles, timer pulses every 8
   always @(posedge sys_clk) begin
      cycles++;
      sub_clk <= cycles[2];
      tmr <= (cycles[2:0] == 3'h0);
      if (cycles == 30000) begin
         failures++;
         test_done();
      end
   end
   ////////////////////////////////////////////////////////////////////////////
   task automatic test_done();
      $display("comparisons %0d failures %0d", comparisons, failures);
      if (failures == 0 && comparisons > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask : test_done
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      comparisons++;
      if (s !== e) begin
         failures++;
         $display("CHECK FAILED t=%0t seen %h expected %h", $time, s, e);
      end
   endtask : chk
   // bus cycles hold everything until waitrequest is seen low
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      wdata <= {24'h0, d};
      wr_en <= 1'b1;
      do @(posedge sys_clk); while (wait_req !== 1'b0);
      wr_en <= 1'b0;
   endtask : wr
   task automatic rd(input logic [4:0] a, output logic [7:0] d);
      @(posedge sys_clk);
      addr <= a;
      rd_en <= 1'b1;
      do @(posedge sys_clk); while (wait_req !== 1'b0);
      d = rdata[7:0];
      rd_en <= 1'b0;
   endtask : rd
   task automatic rc(input logic [4:0] a, input logic [7:0] e);
      logic [7:0] v;
      rd(a, v);
      chk(v, e);
   endtask : rc
   task automatic wait_done();
      logic [7:0] v;
      v = 8'h00;
      while (v[0] !== 1'b1) rd(SSP_OFS_IRQ_ST, v);
   endtask : wait_done
   // one master byte; c adds a write while busy
   task automatic xfer(input logic [7:0] f, input logic [7:0] d, input logic [7:0] t, input logic c);
      pol = f[5];
      edg = f[4];
      msb = f[3];
      tx = t;
      wr(SSP_OFS_FMT, f);
      repeat (2) @(negedge sys_clk);
      chk({7'h0, pin_o.sck_o}, {7'h0, ~f[5]});
      wr(SSP_OFS_DATA, d);
      if (c) wr(SSP_OFS_DATA, 8'h11);
      @(negedge sys_clk);
      chk({5'h0, pin_o.scs_n_oe, pin_o.scs_n_o, pin_o.sck_oe}, 8'h05);
      wait_done();
      chk({7'h0, irq}, 8'h01);
      rc(SSP_OFS_FMT, f | 8'h01 | {6'h0, c, 1'b0});
      rc(SSP_OFS_IRQ_ST, {6'h0, c, 1'b1});
      rc(SSP_OFS_DATA, t);
      chk(rx, d);
      wr(SSP_OFS_IRQ_EN, 8'h00);
      @(negedge sys_clk);
      chk({7'h0, irq}, 8'h00);
      wr(SSP_OFS_IRQ_CLR, 8'h07);
      wr(SSP_OFS_IRQ_EN, 8'h07);
      @(negedge sys_clk);
      chk({7'h0, irq}, 8'h00);
   endtask : xfer
   // far master frame of n clock edges, select held low
   task automatic sframe(input int n);
      @(posedge sys_clk);
      tb_scs_n <= 1'b0;
      repeat (n) begin
         repeat (4) @(posedge sys_clk);
         tb_sck <= ~tb_sck;
      end
      repeat (4) @(posedge sys_clk);
      tb_scs_n <= 1'b1;
      wait_done();
   endtask : sframe
   ////////////////////////////////////////////////////////////////////////////
   initial begin
      {sys_clk, nrst, rd_en, wr_en, pol, edg, msb, addr, wdata, tx, sub_clk, tmr} = '0;
      {pf, tb_sck, tb_scs_n, pu_sel} = 6'h3f;
      {failures, comparisons, cycles} = '0;
      repeat (6) @(posedge sys_clk);
      nrst <= 1'b1;
      rc(SSP_OFS_MODE, SSP_MODE_CTRL_RST);
      rc(SSP_OFS_FMT, SSP_FMT_RST);
      rc(5'h18, 8'h00);
      chk({5'h0, pin_o.sck_oe, pin_o.sdo_oe, pin_o.scs_n_oe}, 8'h00);
      wr(SSP_OFS_MODE, 8'h12);
      rc(SSP_OFS_MODE, 8'h02);
      wr(SSP_OFS_MODE, {SSP_M_DIV16, 5'b00010});
      wr(SSP_OFS_IRQ_EN, 8'h07);
      // every polarity, edge and order; collision on the last
      for (int i = 0; i < 8; i++) xfer({2'b00, 3'(i), 3'b100}, 8'h96 + 8'(i), 8'h1e - 8'(i), i == 7);
      // sub clock and timer rates, trailing capture
      wr(SSP_OFS_MODE, {SSP_M_SUB, 5'b00010});
      xfer(8'h24, 8'h5a, 8'hc3, 1'b0);
      wr(SSP_OFS_MODE, {SSP_M_TMR, 5'b00010});
      xfer(8'h0c, 8'ha5, 8'h3c, 1'b0);
      wr(SSP_OFS_FMT, 8'h00);
      @(negedge sys_clk);
      chk({7'h0, pin_o.scs_n_oe}, 8'h00);
      // slave personality, driven from the far side
      {pol, edg, msb} = 3'b000;
      tx = 8'h6b;
      wr(SSP_OFS_MODE, {SSP_M_SLAVE, 5'b00010});
      wr(SSP_OFS_FMT, 8'h04);
      wr(SSP_OFS_DATA, 8'h4e);
      @(negedge sys_clk);
      chk({4'h0, pin_o.sck_oe, pu_on}, 8'h07);
      sframe(16);
      rc(SSP_OFS_MODE, 8'ha2);
      rc(SSP_OFS_DATA, 8'h6b);
      chk(rx, 8'h4e);
      wr(SSP_OFS_IRQ_CLR, 8'h07);
      sframe(6);
      rc(SSP_OFS_MODE, 8'ha3);
      rc(SSP_OFS_IRQ_ST, 8'h05);
      wr(SSP_OFS_MODE, {SSP_M_TWI, 5'b00010});
      @(negedge sys_clk);
      chk({5'h0, pin_o.sck_oe, pin_o.sdo_oe, pin_o.scs_n_oe}, 8'h00);
      wr(SSP_OFS_MODE, 8'ha0);
      @(negedge sys_clk);
      chk({4'h0, pin_o.sdo_oe, pu_on}, 8'h00);
      test_done();
   end
endmodule : tb
